// File: core/ims_consts.vh
// Shared offsets, field positions and reset values of the two-wire bus block
`ifndef IMS_CONSTS_VH
`define IMS_CONSTS_VH

// ------------------------------------------------------------
// Register byte offsets on APB
// ------------------------------------------------------------
`define IMS_OFS_STATUS 8'h00
`define IMS_OFS_CTRL 8'h04
`define IMS_OFS_ADDR 8'h08
`define IMS_OFS_BAUD 8'h0C
`define IMS_OFS_TXBUF 8'h10
`define IMS_OFS_RXBUF 8'h14
`define IMS_OFS_CMD 8'h18

// ------------------------------------------------------------
// Status fields (bus_status_register)
// ------------------------------------------------------------
`define IMS_ST_COL 10
`define IMS_ST_WCOL 7
`define IMS_ST_OVF 6

// ------------------------------------------------------------
// Control and command fields
// ------------------------------------------------------------
`define IMS_CTRL_EN 0
`define IMS_CTRL_REL 1
`define IMS_CTRL_STR 2
`define IMS_CTRL_TEN 3
`define IMS_CTRL_GCE 4
`define IMS_CMD_START 0
`define IMS_CMD_RSTART 1
`define IMS_CMD_STOP 2
`define IMS_CMD_RECV 3
`define IMS_CMD_ACKV 4

// ------------------------------------------------------------
// Reset values and bus constants
// ------------------------------------------------------------
`define IMS_BAUD_RST 8'hFF
`define IMS_ADDR_RST 10'h000
`define IMS_TEN_HDR 5'h1E
`define IMS_GC_ADDR 8'h00
`define IMS_RXF_W 8
`define IMS_RXF_AW 4

`endif

// File: core/ims_fifo.v
// Receive FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module ims_fifo #(
	parameter W = 8,
	parameter AW = 4
) (
	input wire i_clk, // Core clock
	input wire i_rst, // Synchronous reset, active high
	input wire i_in_valid, // Write request
	output wire o_in_ready, // Space left
	input wire [W-1:0] i_in_data, // Write data
	output wire o_out_valid, // Data available
	input wire i_out_ready, // Read accept
	output wire [W-1:0] o_out_data // Head of queue
);

// ------------------------------------------------------------
// Storage and pointers
// ------------------------------------------------------------
localparam [AW:0] FULL = {1'b1, {AW{1'b0}}};
localparam [AW:0] ONE = {{AW{1'b0}}, 1'b1};
localparam [AW-1:0] STEP = {{(AW-1){1'b0}}, 1'b1};
reg [W-1:0] mem [0:(1<<AW)-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
reg [AW:0] count;
wire do_wr = i_in_valid & o_in_ready;
wire do_rd = o_out_valid & i_out_ready;

// Full and empty come straight from the count, so neither can lie
assign o_in_ready = (count != FULL);
assign o_out_valid = (count != {(AW+1){1'b0}});
assign o_out_data = mem[rd_ptr];

// Pointer and count update
always @(posedge i_clk)
begin
	if (i_rst)
	begin
		wr_ptr <= {AW{1'b0}};
		rd_ptr <= {AW{1'b0}};
		count <= {(AW+1){1'b0}};
	end
	else
	begin
		if (do_wr)
			wr_ptr <= wr_ptr + STEP;
		if (do_rd)
			rd_ptr <= rd_ptr + STEP;
		if (do_wr & ~do_rd)
			count <= count + ONE;
		else if (do_rd & ~do_wr)
			count <= count - ONE;
	end
end

// Data array has no reset; contents are only read while valid
always @(posedge i_clk)
begin
	if (do_wr)
		mem[wr_ptr] <= i_in_data;
end

endmodule // ims_fifo

`default_nettype wire

// File: core/ims_i2c_core.v
// Two-wire bus master/slave engine with APB status and control registers
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ims_consts.vh"

// What this block does
// - Master transmit records slave ACK/NACK at ack end
// - Transmit-progress flag spans byte plus acknowledge
// - Status bits 13 to 11 read zero
// - Bus collision sets flag until software clears
// - General call sets flag, stop clears
// - Second 10-bit address byte match sets flag
// - Transmit write while busy fails, flags collision
// - Byte arriving with full buffer flags overflow
// - Slave address clears, data byte sets flag
// - Stop flag tracks last start or stop
// - Slave answers 7-bit and 10-bit addresses
// - Master sends 7-bit and 10-bit address bytes
// - Clock held low until software releases it
// - Lost arbitration makes the master withdraw
// - Slowest bit rate is clock over 512
// - Registers are 16-bit words to software
module ims_i2c_core (
	input wire i_core_clk, // 125 MHz core clock
	input wire i_sys_rst, // Synchronous reset, active high
	input wire i_psel, // APB select
	input wire i_penable, // APB access phase
	input wire i_pwrite, // APB direction
	input wire [7:0] i_paddr, // APB byte address
	input wire [31:0] i_pwdata, // APB write data
	output reg [31:0] o_prdata, // APB read data
	output wire o_pready, // APB ready
	output wire o_pslverr, // APB error on unmapped address
	input wire i_scl, // serial_clock_pin level
	output wire o_scl, // Driven level, always low
	output reg o_scl_oe, // Pull serial clock low
	input wire i_sda, // serial_data_pin level
	output wire o_sda, // Driven level, always low
	output reg o_sda_oe // Pull serial data low
);

// ------------------------------------------------------------
// States
// ------------------------------------------------------------
localparam MS_IDLE = 3'h0, MS_START = 3'h1, MS_HOLD = 3'h2, MS_LOW = 3'h3;
localparam MS_HIGH = 3'h4, MS_STOP = 3'h5, MS_RSTART = 3'h6;
localparam SS_IDLE = 3'h0, SS_RX = 3'h1, SS_ACK = 3'h2, SS_TX = 3'h3;
localparam SS_TACK = 3'h4, SS_HOLD = 3'h5;
localparam PH_ADR = 2'h0, PH_ADR2 = 2'h1, PH_DAT = 2'h2;

// ------------------------------------------------------------
// Pin synchronisers: bit 1 clock, bit 0 data
// ------------------------------------------------------------
reg [1:0] pin_s1;
reg [1:0] pin_s2;
reg [1:0] pin_s3;
reg [1:0] pin_f;
reg [1:0] pin_p;
wire [1:0] pin_diff = pin_s2 ^ pin_s3;

// A level is accepted only once two stages agree, which rejects one-cycle glitches
always @(posedge i_core_clk)
begin
	if (i_sys_rst)
	begin
		pin_s1 <= 2'h3;
		pin_s2 <= 2'h3;
		pin_s3 <= 2'h3;
		pin_f <= 2'h3;
		pin_p <= 2'h3;
	end
	else
	begin
		pin_s1 <= {i_scl, i_sda};
		pin_s2 <= pin_s1;
		pin_s3 <= pin_s2;
		pin_f <= (pin_s3 & ~pin_diff) | (pin_f & pin_diff);
		pin_p <= pin_f;
	end
end

wire scl_f = pin_f[1];
wire sda_f = pin_f[0];
wire scl_rise = scl_f & ~pin_p[1];
wire scl_fall = ~scl_f & pin_p[1];
wire start_det = scl_f & pin_p[1] & pin_p[0] & ~sda_f;
wire stop_det = scl_f & pin_p[1] & ~pin_p[0] & sda_f;

// ------------------------------------------------------------
// APB decode
// ------------------------------------------------------------
wire apb_acc = i_psel & i_penable;
wire apb_wr = apb_acc & i_pwrite;
wire hit = (i_paddr == `IMS_OFS_STATUS) | (i_paddr == `IMS_OFS_CTRL) |
	(i_paddr == `IMS_OFS_ADDR) | (i_paddr == `IMS_OFS_BAUD) |
	(i_paddr == `IMS_OFS_TXBUF) | (i_paddr == `IMS_OFS_RXBUF) |
	(i_paddr == `IMS_OFS_CMD);
wire wr_stat = apb_wr & (i_paddr == `IMS_OFS_STATUS);
wire wr_ctrl = apb_wr & (i_paddr == `IMS_OFS_CTRL);
wire wr_addr = apb_wr & (i_paddr == `IMS_OFS_ADDR);
wire wr_baud = apb_wr & (i_paddr == `IMS_OFS_BAUD);
wire wr_tx = apb_wr & (i_paddr == `IMS_OFS_TXBUF);
wire wr_cmd = apb_wr & (i_paddr == `IMS_OFS_CMD);
wire rx_pop = apb_acc & ~i_pwrite & (i_paddr == `IMS_OFS_RXBUF);
wire cmd_start = wr_cmd & i_pwdata[`IMS_CMD_START];
wire cmd_rstart = wr_cmd & i_pwdata[`IMS_CMD_RSTART];
wire cmd_stop = wr_cmd & i_pwdata[`IMS_CMD_STOP];
wire cmd_recv = wr_cmd & i_pwdata[`IMS_CMD_RECV];

// Zero-wait slave; an unmapped address answers with an error
assign o_pready = 1'b1;
assign o_pslverr = apb_acc & ~hit;
assign o_scl = 1'b0;
assign o_sda = 1'b0;

// ------------------------------------------------------------
// Registers, flags and engine state
// ------------------------------------------------------------
reg ctrl_en, rel_ctl, ctrl_str, ctrl_ten, ctrl_gce;
reg [9:0] own_addr;
reg [7:0] baud;
reg [7:0] tx_data;
reg tx_full, bus_busy;
reg f_ack, f_txp, f_col, f_gc, f_ten, f_wcol, f_ovf, f_da, f_stop, f_start;
reg [2:0] m_state;
reg [1:0] m_ph;
reg [8:0] m_sh;
reg [3:0] m_cnt;
reg m_tx, m_scl, m_sda;
reg [7:0] tmr;
reg [2:0] s_state;
reg [1:0] s_ph;
reg [7:0] s_sh;
reg [3:0] s_cnt;
reg s_rd, s_mack, s_tenm, s_scl, s_sda;
reg push_v;
reg [7:0] push_d;
wire rx_rdy;
wire rx_vld;
wire [7:0] rx_head;

wire tmr_done = (tmr == 8'h00);
wire busy = tx_full | (s_state == SS_TX) | ~((m_state == MS_IDLE) | (m_state == MS_HOLD));
wire gc_hit = ctrl_gce & (s_sh == `IMS_GC_ADDR);
wire m7_hit = ~ctrl_ten & (s_sh[7:1] == own_addr[6:0]);
wire t1_hit = ctrl_ten & (s_sh[7:3] == `IMS_TEN_HDR) & (s_sh[2:1] == own_addr[9:8]);
wire s_go_tx = (s_state == SS_ACK) ? s_rd : s_mack;
wire [15:0] stat = {f_ack, f_txp, 3'h0, f_col, f_gc, f_ten, f_wcol, f_ovf,
	f_da, f_stop, f_start, s_rd, rx_vld, tx_full};

// ------------------------------------------------------------
// Core process: software writes first, hardware events later so a set wins
// ------------------------------------------------------------
always @(posedge i_core_clk)
begin
	if (i_sys_rst)
	begin
		ctrl_en <= 1'b0;
		rel_ctl <= 1'b1;
		ctrl_str <= 1'b0;
		ctrl_ten <= 1'b0;
		ctrl_gce <= 1'b0;
		own_addr <= `IMS_ADDR_RST;
		baud <= `IMS_BAUD_RST;
		tx_data <= 8'h00;
		tx_full <= 1'b0;
		bus_busy <= 1'b0;
		{f_ack, f_txp, f_col, f_gc, f_ten} <= 5'h00;
		{f_wcol, f_ovf, f_da, f_stop, f_start} <= 5'h00;
		m_state <= MS_IDLE;
		m_ph <= 2'h0;
		m_sh <= 9'h000;
		m_cnt <= 4'h0;
		{m_tx, m_scl, m_sda} <= 3'h0;
		tmr <= 8'h00;
		s_state <= SS_IDLE;
		s_ph <= PH_ADR;
		s_sh <= 8'h00;
		s_cnt <= 4'h0;
		{s_rd, s_mack, s_tenm, s_scl, s_sda} <= 5'h00;
		push_v <= 1'b0;
		push_d <= 8'h00;
	end
	else
	begin
		push_v <= 1'b0;
		if (!tmr_done)
			tmr <= tmr - 8'h01;
		// Software side
		if (wr_ctrl)
		begin
			ctrl_en <= i_pwdata[`IMS_CTRL_EN];
			rel_ctl <= i_pwdata[`IMS_CTRL_REL];
			ctrl_str <= i_pwdata[`IMS_CTRL_STR];
			ctrl_ten <= i_pwdata[`IMS_CTRL_TEN];
			ctrl_gce <= i_pwdata[`IMS_CTRL_GCE];
		end
		if (wr_addr)
			own_addr <= i_pwdata[9:0];
		if (wr_baud)
			baud <= i_pwdata[7:0];
		if (wr_stat)
		begin
			if (~i_pwdata[`IMS_ST_COL])
				f_col <= 1'b0;
			if (~i_pwdata[`IMS_ST_WCOL])
				f_wcol <= 1'b0;
			if (~i_pwdata[`IMS_ST_OVF])
				f_ovf <= 1'b0;
		end
		if (wr_tx)
		begin
			if (busy)
				f_wcol <= 1'b1;
			else
			begin
				tx_data <= i_pwdata[7:0];
				tx_full <= 1'b1;
			end
		end
		// Bus conditions seen on the pins, our own included
		if (start_det)
		begin
			bus_busy <= 1'b1;
			f_start <= 1'b1;
			f_stop <= 1'b0;
		end
		if (stop_det)
		begin
			bus_busy <= 1'b0;
			f_start <= 1'b0;
			f_stop <= 1'b1;
			f_gc <= 1'b0;
			f_ten <= 1'b0;
		end
		// Master engine; every bit half lasts baud+1 cycles at least
		if (~ctrl_en)
		begin
			m_state <= MS_IDLE;
			m_scl <= 1'b0;
			m_sda <= 1'b0;
		end
		else
		begin
			case (m_state)
			MS_IDLE:
			begin
				m_scl <= 1'b0;
				m_sda <= 1'b0;
				if (cmd_start & bus_busy)
					f_col <= 1'b1;
				else if (cmd_start)
				begin
					m_sda <= 1'b1;
					tmr <= baud;
					m_state <= MS_START;
				end
			end
			MS_START:
				if (tmr_done)
				begin
					m_scl <= 1'b1;
					tmr <= baud;
					m_state <= MS_HOLD;
				end
			MS_HOLD:
			begin
				// Clock stays low here, which suspends the bus until software acts
				m_sda <= 1'b0;
				m_cnt <= 4'h0;
				tmr <= baud;
				m_ph <= 2'h0;
				if (tx_full)
				begin
					m_sh <= {tx_data, 1'b1};
					m_tx <= 1'b1;
					tx_full <= 1'b0;
					f_txp <= 1'b1;
					m_state <= MS_LOW;
				end
				else if (cmd_recv)
				begin
					m_sh <= {8'hFF, i_pwdata[`IMS_CMD_ACKV]};
					m_tx <= 1'b0;
					m_state <= MS_LOW;
				end
				else if (cmd_stop)
				begin
					m_sda <= 1'b1;
					m_state <= MS_STOP;
				end
				else if (cmd_rstart)
					m_state <= MS_RSTART;
			end
			MS_LOW:
			begin
				// Data moves one cycle after the clock fell
				m_sda <= ~m_sh[8];
				if (tmr_done)
				begin
					m_scl <= 1'b0;
					tmr <= baud;
					m_state <= MS_HIGH;
				end
			end
			MS_HIGH:
			begin
				if (~scl_f)
					tmr <= baud;
				else if (tmr_done)
				begin
					if (m_tx & (m_cnt != 4'h8) & m_sh[8] & ~sda_f)
					begin
						m_scl <= 1'b0;
						m_sda <= 1'b0;
						f_col <= 1'b1;
						f_txp <= 1'b0;
						m_state <= MS_IDLE;
					end
					else
					begin
						m_sh <= {m_sh[7:0], sda_f};
						m_scl <= 1'b1;
						tmr <= baud;
						m_cnt <= m_cnt + 4'h1;
						m_state <= MS_LOW;
						if (m_cnt == 4'h8)
						begin
							m_state <= MS_HOLD;
							if (m_tx)
							begin
								f_ack <= sda_f;
								f_txp <= 1'b0;
							end
							else if (rx_rdy)
							begin
								push_v <= 1'b1;
								push_d <= m_sh[7:0];
							end
							else
								f_ovf <= 1'b1;
						end
					end
				end
			end
			MS_STOP:
			begin
				if ((m_ph == 2'h0) & tmr_done)
				begin
					m_scl <= 1'b0;
					tmr <= baud;
					m_ph <= 2'h1;
				end
				else if ((m_ph == 2'h1) & ~scl_f)
					tmr <= baud;
				else if ((m_ph == 2'h1) & tmr_done)
				begin
					m_sda <= 1'b0;
					tmr <= baud;
					m_ph <= 2'h2;
				end
				else if ((m_ph == 2'h2) & tmr_done)
					m_state <= MS_IDLE;
			end
			MS_RSTART:
			begin
				if ((m_ph == 2'h0) & tmr_done)
				begin
					m_scl <= 1'b0;
					tmr <= baud;
					m_ph <= 2'h1;
				end
				else if ((m_ph == 2'h1) & ~scl_f)
					tmr <= baud;
				else if ((m_ph == 2'h1) & tmr_done)
				begin
					m_sda <= 1'b1;
					tmr <= baud;
					m_ph <= 2'h2;
				end
				else if ((m_ph == 2'h2) & tmr_done)
				begin
					m_scl <= 1'b1;
					tmr <= baud;
					m_state <= MS_HOLD;
				end
			end
			default:
				m_state <= MS_IDLE;
			endcase
		end
		// Slave engine; it listens only while the master side is idle
		if (~ctrl_en | (m_state != MS_IDLE) | stop_det)
		begin
			s_state <= SS_IDLE;
			s_scl <= 1'b0;
			s_sda <= 1'b0;
			if (stop_det)
				s_tenm <= 1'b0;
		end
		else if (start_det)
		begin
			s_state <= SS_RX;
			s_cnt <= 4'h0;
			s_ph <= PH_ADR;
			s_sda <= 1'b0;
		end
		else
		begin
			case (s_state)
			SS_IDLE:
				s_sda <= 1'b0;
			SS_RX:
				if (scl_rise)
				begin
					s_sh <= {s_sh[6:0], sda_f};
					s_cnt <= s_cnt + 4'h1;
				end
				else if (scl_fall & (s_cnt == 4'h8))
				begin
					// Not addressed or refused unless a branch acknowledges
					s_state <= SS_IDLE;
					if ((s_ph == PH_DAT) & rx_rdy)
					begin
						push_v <= 1'b1;
						push_d <= s_sh;
						f_da <= 1'b1;
						s_sda <= 1'b1;
						s_state <= SS_ACK;
					end
					else if (s_ph == PH_DAT)
						f_ovf <= 1'b1;
					else if ((s_ph == PH_ADR2) & (s_sh == own_addr[7:0]))
					begin
						f_ten <= 1'b1;
						s_tenm <= 1'b1;
						f_da <= 1'b0;
						s_ph <= PH_DAT;
						s_sda <= 1'b1;
						s_state <= SS_ACK;
					end
					else if ((s_ph == PH_ADR) & (gc_hit | m7_hit))
					begin
						if (gc_hit)
							f_gc <= 1'b1;
						f_da <= 1'b0;
						s_rd <= s_sh[0] & ~gc_hit;
						s_ph <= PH_DAT;
						s_sda <= 1'b1;
						s_state <= SS_ACK;
					end
					else if ((s_ph == PH_ADR) & t1_hit & (~s_sh[0] | s_tenm))
					begin
						s_rd <= s_sh[0];
						s_ph <= s_sh[0] ? PH_DAT : PH_ADR2;
						if (s_sh[0])
							f_da <= 1'b0;
						s_sda <= 1'b1;
						s_state <= SS_ACK;
					end
				end
			SS_ACK, SS_TACK:
			begin
				if (scl_rise)
					s_mack <= ~sda_f;
				if (scl_fall)
				begin
					s_sda <= 1'b0;
					s_cnt <= 4'h0;
					if ((s_state == SS_TACK) & ~s_mack)
						s_state <= SS_IDLE;
					else if (ctrl_str)
					begin
						s_scl <= 1'b1;
						rel_ctl <= 1'b0;
						s_mack <= s_go_tx;
						s_state <= SS_HOLD;
					end
					else if (s_go_tx)
					begin
						s_sh <= tx_data;
						s_sda <= ~tx_data[7];
						tx_full <= 1'b0;
						s_state <= SS_TX;
					end
					else
						s_state <= SS_RX;
				end
			end
			SS_HOLD:
			begin
				// Data is set up while the clock is still held, never at release
				if (s_go_tx)
				begin
					s_sh <= tx_data;
					s_sda <= ~tx_data[7];
				end
				if (rel_ctl)
				begin
					s_scl <= 1'b0;
					s_state <= s_go_tx ? SS_TX : SS_RX;
					if (s_go_tx)
						tx_full <= 1'b0;
				end
			end
			SS_TX:
				if (scl_fall)
				begin
					s_cnt <= s_cnt + 4'h1;
					if (s_cnt == 4'h7)
					begin
						s_sda <= 1'b0;
						s_state <= SS_TACK;
					end
					else
					begin
						s_sh <= {s_sh[6:0], 1'b0};
						s_sda <= ~s_sh[6];
					end
				end
			default:
				s_state <= SS_IDLE;
			endcase
		end
	end
end

// ------------------------------------------------------------
// Read data, captured in the setup phase; 16-bit words in the low half
// ------------------------------------------------------------
always @(posedge i_core_clk)
begin
	if (i_sys_rst)
		o_prdata <= 32'h00000000;
	else if (i_psel & ~i_penable & ~i_pwrite)
	begin
		case (i_paddr)
		`IMS_OFS_STATUS: o_prdata <= {16'h0000, stat};
		`IMS_OFS_CTRL: o_prdata <= {27'h0000000, ctrl_gce, ctrl_ten, ctrl_str, rel_ctl, ctrl_en};
		`IMS_OFS_ADDR: o_prdata <= {22'h000000, own_addr};
		`IMS_OFS_BAUD: o_prdata <= {24'h000000, baud};
		`IMS_OFS_TXBUF: o_prdata <= {24'h000000, tx_data};
		`IMS_OFS_RXBUF: o_prdata <= {24'h000000, rx_head};
		default: o_prdata <= 32'h00000000;
		endcase
	end
end

// ------------------------------------------------------------
// Pin drivers: both engines may pull, registered to keep glitches off the wire
// ------------------------------------------------------------
always @(posedge i_core_clk)
begin
	if (i_sys_rst)
	begin
		o_scl_oe <= 1'b0;
		o_sda_oe <= 1'b0;
	end
	else
	begin
		o_scl_oe <= m_scl | s_scl;
		o_sda_oe <= m_sda | s_sda;
	end
end

// ------------------------------------------------------------
// Receive buffer; a full queue turns a finished byte into an overflow
// ------------------------------------------------------------
ims_fifo #(
	.W(`IMS_RXF_W),
	.AW(`IMS_RXF_AW)
) u_rx_fifo (
	.i_clk(i_core_clk),
	.i_rst(i_sys_rst),
	.i_in_valid(push_v),
	.o_in_ready(rx_rdy),
	.i_in_data(push_d),
	.o_out_valid(rx_vld),
	.i_out_ready(rx_pop),
	.o_out_data(rx_head)
);

endmodule // ims_i2c_core

`default_nettype wire

// File: verif/ims_i2c_core_tb_top.sv
// Self-checking bench for the two-wire bus block
`timescale 1ns/1ps
`default_nettype none
`include "ims_consts.vh"
module ims_i2c_core_tb_top;
	logic clk, rst, psel, pen, pwr, err, ack, pready, pslverr, scl_oe, sda_oe, p_scl, p_sda;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	wire logic scl = !(scl_oe || p_scl);
	wire logic sda = !(sda_oe || p_sda);
	int miscompares, num_checks;
	ims_i2c_core i_ims_i2c_core (.i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_scl(scl), .o_scl(), .o_scl_oe(scl_oe),
		.i_sda(sda), .o_sda(), .o_sda_oe(sda_oe));
	ims_peer i_ims_peer (.i_clk(clk), .i_scl(scl), .i_sda(sda), .o_scl_oe(p_scl), .o_sda_oe(p_sda));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	// One APB transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1)
			@(posedge clk);
		r = prdata;
		err = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
		@(posedge clk);
	endtask
	// Poll one status bit until it reaches a level
	task automatic wait_st(input int b, input logic v);
		apb(1'h0, `IMS_OFS_STATUS, 32'h0);
		while (r[b] !== v)
			apb(1'h0, `IMS_OFS_STATUS, 32'h0);
	endtask
	task automatic t_regs;
		apb(1'h0, `IMS_OFS_STATUS, 32'h0);
		chk(r, 32'h0);
		apb(1'h0, `IMS_OFS_CTRL, 32'h0);
		chk(r, 32'h2);
		apb(1'h0, `IMS_OFS_BAUD, 32'h0);
		chk(r, 32'hFF);
		apb(1'h1, `IMS_OFS_STATUS, 32'hFFFF);
		apb(1'h0, `IMS_OFS_STATUS, 32'h0);
		chk(r, 32'h0);
		apb(1'h0, 8'h1C, 32'h0);
		chkb(err, 1'h1);
		$display("regs test done");
	endtask
	task automatic t_master;
		apb(1'h1, `IMS_OFS_BAUD, 32'h2);
		apb(1'h1, `IMS_OFS_CTRL, 32'h3);
		apb(1'h1, `IMS_OFS_CMD, 32'h1);
		while (scl_oe !== 1'h1)
			@(posedge clk);
		apb(1'h1, `IMS_OFS_TXBUF, 32'h74);
		apb(1'h1, `IMS_OFS_TXBUF, 32'h0);
		apb(1'h0, `IMS_OFS_STATUS, 32'h0);
		chkb(r[14], 1'h1);
		chkb(r[7], 1'h1);
		wait_st(14, 1'h0);
		chkb(r[15], 1'h0);
		apb(1'h1, `IMS_OFS_STATUS, 32'hFF7F);
		apb(1'h0, `IMS_OFS_STATUS, 32'h0);
		chkb(r[7], 1'h0);
		apb(1'h1, `IMS_OFS_TXBUF, 32'h55);
		wait_st(14, 1'h0);
		chkb(r[15], 1'h1);
		apb(1'h1, `IMS_OFS_CMD, 32'h4);
		wait_st(4, 1'h1);
		chkb(r[4], 1'h1);
		// Far side holds data low, so the first released bit loses arbitration
		apb(1'h1, `IMS_OFS_CMD, 32'h1);
		while (scl_oe !== 1'h1)
			@(posedge clk);
		i_ims_peer.m_sda <= 1'h1;
		apb(1'h1, `IMS_OFS_TXBUF, 32'h80);
		wait_st(14, 1'h0);
		chkb(r[10], 1'h1);
		chk({scl_oe, sda_oe}, 32'h0);
		i_ims_peer.m_sda <= 1'h0;
		apb(1'h1, `IMS_OFS_STATUS, 32'hFBFF);
		wait_st(4, 1'h1);
		chkb(r[10], 1'h0);
		$display("master test done");
	endtask
	// FIFO filled to refusal then drained; general call with clock stretch
	task automatic t_slave;
		apb(1'h1, `IMS_OFS_ADDR, 32'h21);
		apb(1'h1, `IMS_OFS_CTRL, 32'h13);
		i_ims_peer.mstart();
		i_ims_peer.mbyte(8'h42, ack);
		chkb(ack, 1'h0);
		apb(1'h0, `IMS_OFS_STATUS, 32'h0);
		chkb(r[5], 1'h0);
		for (int i = 0; i < 17; i++)
		begin
			i_ims_peer.mbyte(8'h80 + 8'(i), ack);
			chkb(ack, i == 16);
		end
		apb(1'h0, `IMS_OFS_STATUS, 32'h0);
		chk({r[6:5], r[1]}, 32'h7);
		i_ims_peer.mstop();
		wait_st(4, 1'h1);
		chkb(r[4], 1'h1);
		for (int i = 0; i < 16; i++)
		begin
			apb(1'h0, `IMS_OFS_RXBUF, 32'h0);
			chk(r, 32'h80 + i);
		end
		apb(1'h1, `IMS_OFS_STATUS, 32'hFFBF);
		apb(1'h0, `IMS_OFS_STATUS, 32'h0);
		chk({r[6], r[1]}, 32'h0);
		apb(1'h1, `IMS_OFS_CTRL, 32'h17);
		i_ims_peer.mstart();
		apb(1'h1, `IMS_OFS_CMD, 32'h1);
		i_ims_peer.mbyte(8'h00, ack);
		chkb(ack, 1'h0);
		chkb(scl_oe, 1'h1);
		apb(1'h0, `IMS_OFS_STATUS, 32'h0);
		chk({r[10:9], r[4]}, 32'h6);
		apb(1'h1, `IMS_OFS_CTRL, 32'h17);
		repeat (4) @(posedge clk);
		chkb(scl_oe, 1'h0);
		i_ims_peer.mstop();
		wait_st(4, 1'h1);
		chkb(r[9], 1'h0);
		// Ten-bit write address: header with the upper bits, then the low byte
		apb(1'h1, `IMS_OFS_ADDR, 32'h2A5);
		apb(1'h1, `IMS_OFS_CTRL, 32'hB);
		i_ims_peer.mstart();
		i_ims_peer.mbyte(8'hF4, ack);
		chkb(ack, 1'h0);
		i_ims_peer.mbyte(8'hA5, ack);
		chkb(ack, 1'h0);
		apb(1'h0, `IMS_OFS_STATUS, 32'h0);
		chk({r[8], r[5]}, 32'h2);
		i_ims_peer.mstop();
		wait_st(4, 1'h1);
		chkb(r[8], 1'h0);
		$display("slave test done");
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		clk = 1'h0;
		forever #4 clk = !clk;
	end
	// Watchdog sized well past the longest expected run
	initial
	begin
		repeat (100000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end
	initial
	begin
		{rst, psel, pen, pwr, paddr, pwdata} = {4'h8, 8'h0, 32'h0};
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		t_regs();
		t_master();
		t_slave();
		report_and_stop();
	end
endmodule // ims_i2c_core_tb_top
`default_nettype wire

// File: verif/ims_i2c_sva.sv
// Port checks of the two-wire bus block
`timescale 1ns/1ps
`default_nettype none
module ims_i2c_sva (
	input wire logic i_core_clk, // Core clock
	input wire logic i_sys_rst, // Sync reset
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB access
	input wire logic i_pwrite, // APB direction
	input wire logic [7:0] i_paddr, // APB address
	input wire logic [31:0] o_prdata, // Read data
	input wire logic o_pready, // Ready
	input wire logic o_pslverr, // Error
	input wire logic o_scl, // Clock level
	input wire logic o_scl_oe, // Clock pull
	input wire logic o_sda, // Data level
	input wire logic o_sda_oe // Data pull
);
	// ----------
	// Decode
	// ----------
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	// Mapped words are aligned and end at the command word
	wire logic acc = i_psel && i_penable;
	wire logic rd = acc && !i_pwrite;
	wire logic mapped = i_paddr <= 8'h18 && i_paddr[1:0] == 2'h0;
	ready_high_a: assert property (o_pready) else $error("ready low");
	open_drain_a: assert property (!o_scl && !o_sda) else $error("pin driven high");
	bad_addr_a: assert property (acc && !mapped |-> o_pslverr)
		else $error("no error on unmapped word");
	good_addr_a: assert property ((!acc || mapped) |-> !o_pslverr)
		else $error("error on mapped word");
	cmd_zero_a: assert property (rd && (i_paddr == 8'h18 || !mapped) |-> o_prdata == 32'h0)
		else $error("write-only word reads nonzero");
	status_gap_a: assert property (rd && i_paddr == 8'h00 |->
		o_prdata[31:16] == 16'h0 && o_prdata[13:11] == 3'h0)
		else $error("unused status bits set");
	read_hold_a: assert property (!(i_psel && !i_penable && !i_pwrite) |=> $stable(o_prdata))
		else $error("read data moved");
	reset_idle_a: assert property (disable iff (1'h0) i_sys_rst |=> !o_scl_oe && !o_sda_oe)
		else $error("pins pulled in reset");
endmodule // ims_i2c_sva
bind ims_i2c_core ims_i2c_sva i_ims_i2c_sva (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_scl(o_scl),
	.o_scl_oe(o_scl_oe), .o_sda(o_sda), .o_sda_oe(o_sda_oe));
`default_nettype wire

// File: verif/ims_peer.sv
// Far-side bus device: address-matching slave and scripted master
`timescale 1ns/1ps
`default_nettype none
module ims_peer #(
	parameter logic [6:0] ACK_ADDR = 7'h3A,
	parameter int HP = 20
) (
	input wire logic i_clk, // Core clock
	input wire logic i_scl, // Clock line
	input wire logic i_sda, // Data line
	output var logic o_scl_oe, // Pull clock low
	output logic o_sda_oe // Pull data low
);
	logic [3:0] bits = 4'h0;
	logic [7:0] sh = 8'h0;
	logic s_oe = 1'h0;
	logic m_sda = 1'h0;
	initial o_scl_oe = 1'h0;
	// A start restarts the bit count
	always @(negedge i_sda)
		if (i_scl)
			bits = 4'h0;
	// Count saturates, so only the address byte is ever answered
	always @(posedge i_scl)
	begin
		sh = {sh[6:0], i_sda};
		if (bits != 4'hF)
			bits = bits + 4'h1;
	end
	always @(negedge i_scl)
		s_oe = bits == 4'h8 && sh[7:1] == ACK_ADDR;
	assign o_sda_oe = m_sda || s_oe;
	// Master steps: set both lines, hold a third of a bit
	task automatic put(input logic c, input logic d);
		o_scl_oe <= !c;
		m_sda <= !d;
		@(posedge i_clk);
		if (c)
			wait (i_scl === 1'h1);
		repeat (HP) @(posedge i_clk);
	endtask
	task automatic mstart;
		put(1'h1, 1'h1);
		put(1'h1, 1'h0);
		put(1'h0, 1'h0);
	endtask
	// Data moves only while the clock is low
	task automatic mbit(input logic d, output logic s);
		put(1'h0, d);
		put(1'h1, d);
		s = i_sda;
		put(1'h0, d);
	endtask
	task automatic mbyte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
			mbit(b[i], ack);
		mbit(1'h1, ack);
	endtask
	task automatic mstop;
		put(1'h0, 1'h0);
		put(1'h1, 1'h0);
		put(1'h1, 1'h1);
	endtask
endmodule // ims_peer
`default_nettype wire
